// ---- src/vgr_map.svh ----
// Register offsets, field positions and reset values of the general VGA group.
`ifndef VGR_MAP_SVH
`define VGR_MAP_SVH
`define VGR_PORT_CRTC_IDX_MONO   16'h03b4
`define VGR_PORT_CRTC_DAT_MONO   16'h03b5
`define VGR_PORT_STAT1_MONO      16'h03ba
`define VGR_PORT_CRTC_IDX_COL    16'h03d4
`define VGR_PORT_CRTC_DAT_COL    16'h03d5
`define VGR_PORT_STAT1_COL       16'h03da
`define VGR_PORT_MISC_WR         16'h03c2
`define VGR_PORT_MISC_RD         16'h03cc
`define VGR_PORT_FEAT_RD         16'h03ca
`define VGR_PORT_PAL_MASK        16'h03c6
`define VGR_PORT_PAL_RIDX        16'h03c7
`define VGR_PORT_PAL_WIDX        16'h03c8
`define VGR_PORT_PAL_DATA        16'h03c9
`define VGR_WIN_BASE             20'h0_4000
`define VGR_WIN_LAST             20'h0_4FFF
`define VGR_MISC_COLOUR_BIT      0
`define VGR_MISC_VRAM_BIT        1
`define VGR_MISC_ODDEVEN_BIT     5
`define VGR_FEAT_VBLANK_OR_BIT   3
`define VGR_STAT0_IRQ_BIT        7
`define VGR_STAT1_ACTIVE_BIT     0
`define VGR_STAT1_VSYNC_BIT      3
`define VGR_MISC_RESET           8'h00
`define VGR_FEAT_RESET           8'h00
`define VGR_INDEX_RESET          8'h00
`define VGR_PHASE_LAST           2'h2
`define VGR_STATE_READ           8'h03
`define VGR_STATE_WRITE          8'h00
`endif

// ---- src/vgr_pkg.sv ----
// Types shared by the general VGA register group.
package vgr_pkg;
  typedef struct packed {
    logic [1:0] retrace_pulse_sense;
    logic       odd_even_bank_choice;
    logic       reserved4;
    logic [1:0] dot_clock_choice;
    logic       host_vram_access_gate;
    logic       port_base_colour_select;
  } vgr_misc_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] addr;
    logic [7:0] data;
  } vgr_dac_req_s;

  typedef enum logic [1:0] {
    VGR_HEIGHT_400 = 2'b00,
    VGR_HEIGHT_350 = 2'b01,
    VGR_HEIGHT_480 = 2'b10
  } vgr_height_e;
endpackage

// ---- src/vgr_general_regs.sv ----
// General VGA registers and palette port pass-through to the palette DAC.
//
// Function
// - Misc bit 0 moves CRTC/status ports.
// - Misc bit 1 gates host display memory.
// - Misc bits 2-3 drive dot clock select.
// - Misc bit 5, inverted, replaces LSB in even/odd.
// - Misc bits 6-7 set sync polarities.
// - Same bits report height, not timing.
// - Feature bit 3 ORs active video into vsync.
// - Status 0 switch sense reads zero.
// - Status 0 bit 7 shows vertical interrupt.
// - Status 1 bit 0 shows synced blanking.
// - Status 1 bit 3 shows synced vsync.
// - Status 1 bits 4-5 muxed pixel bits.
// - Status 1 read clears attribute toggle.
// - Read index write-only, advances every third read.
// - Write index advances every third write.
// - Data port moves red, green, blue triplets.
// - State port returns 0 or 3.
// - Palette writes forwarded to external DAC.
// - Registers also in 4K memory window.
// - Window ignores colour decode, needs unit enable.
`timescale 1ns/100ps
`include "vgr_map.svh"
module vgr_general_regs
(
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        IO_WR_IN,
  input  wire logic        IO_RD_IN,
  input  wire logic [15:0] IO_ADDR_IN,
  input  wire logic        MEM_WR_IN,
  input  wire logic        MEM_RD_IN,
  input  wire logic [19:0] MEM_ADDR_IN,
  input  wire logic [7:0]  WR_DATA_IN,
  input  wire logic        LEGACY_UNIT_ON_IN,
  input  wire logic        COLOUR_DECODE_GATE_IN,
  input  wire logic        VIDEO_HSYNC_IN,
  input  wire logic        VIDEO_VSYNC_IN,
  input  wire logic        HORIZ_ACTIVE_IN,
  input  wire logic        VERT_ACTIVE_IN,
  input  wire logic [7:0]  PIXEL_FIFO_IN,
  input  wire logic [1:0]  PIXEL_PROBE_SELECT_IN,
  input  wire logic        VERT_IRQ_PENDING_IN,
  input  wire logic        SEQ_INTERLEAVE_IN,
  input  wire logic        GFX_CHAIN_ODD_EVEN_IN,
  input  wire logic        FOUR_PLANE_CHAIN_IN,
  input  wire logic        HOST_VRAM_LSB_IN,
  input  wire logic [7:0]  DAC_RD_DATA_IN,
  output logic [7:0]  RD_DATA_OUT,
  output logic        RD_VALID_OUT,
  output logic        CRTC_IDX_SEL_OUT,
  output logic        CRTC_DAT_SEL_OUT,
  output logic        HOST_VRAM_ENABLE_OUT,
  output logic        VRAM_ADDR_LSB_OUT,
  output logic [1:0]  DOT_CLOCK_CHOICE_OUT,
  output logic        HSYNC_OUT,
  output logic        VSYNC_OUT,
  output logic [1:0]  SCREEN_HEIGHT_OUT,
  output logic        ATTR_TOGGLE_CLEAR_OUT,
  output logic        DAC_WR_OUT,
  output logic        DAC_RD_OUT,
  output logic [1:0]  DAC_ADDR_OUT,
  output logic [7:0]  DAC_WR_DATA_OUT
);

  vgr_pkg::vgr_misc_s    misc_output_control_r;
  logic [7:0]            feature_sync_control_r;
  logic [7:0]            palette_read_pointer_r;
  logic [7:0]            palette_write_pointer_r;
  logic [1:0]            read_phase_r;
  logic [1:0]            write_phase_r;
  logic                  previous_palette_direction_r;
  vgr_pkg::vgr_dac_req_s dac_req_r;
  logic [7:0]            rd_data_r;
  logic                  rd_valid_r;
  logic                  attr_clear_r;
  logic [11:0]           meta_r;
  logic [11:0]           sync_r;
  logic [11:0]           async_in;
  logic                  win_hit;
  logic                  io_hit;
  logic                  wr_any;
  logic                  rd_any;
  logic [15:0]           port;
  logic [15:0]           stat1_port;
  logic                  mono_ok;
  logic                  col_ok;
  logic                  stat1_hit;
  logic                  vsync_base;
  logic                  active_video_flag;
  logic [1:0]            pixel_pair;
  logic [7:0]            rd_data_nxt;
  logic                  pal_mask_hit;
  logic                  pal_ridx_hit;
  logic                  pal_widx_hit;
  logic                  pal_data_hit;
  logic                  pal_port_hit;
  logic                  misc_wr_hit;
  logic                  feat_wr_hit;
  logic                  interleave_mode;
  logic                  hs_invert;
  logic                  vs_invert;
  logic [7:0]            stat0_word;
  logic [7:0]            stat1_word;

  // Video-domain levels pass two flip-flops before any logic reads them.
  assign async_in = {PIXEL_FIFO_IN, VERT_ACTIVE_IN, HORIZ_ACTIVE_IN,
                     VIDEO_VSYNC_IN, VIDEO_HSYNC_IN};

  genvar gi;
  generate
    for (gi = 0; gi < 12; gi = gi + 1)
    begin : g_sync
      always_ff @(posedge CLK_SYS_IN)
      begin
        if (!RST_N_IN)
        begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
        end
        else
        begin
          meta_r[gi] <= async_in[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  // The memory window passes both port variants, I/O honours the gate.
  assign win_hit = LEGACY_UNIT_ON_IN && (MEM_WR_IN || MEM_RD_IN) &&
                   MEM_ADDR_IN >= `VGR_WIN_BASE &&
                   MEM_ADDR_IN <= `VGR_WIN_LAST;
  assign io_hit  = IO_WR_IN || IO_RD_IN;
  assign wr_any  = IO_WR_IN || (win_hit && MEM_WR_IN);
  assign rd_any  = IO_RD_IN || (win_hit && MEM_RD_IN);
  assign port    = io_hit ? IO_ADDR_IN : {4'h0, 12'h3ff & MEM_ADDR_IN[11:0]};

  // Window accesses see both bases; I/O follows the colour select bit.
  assign mono_ok = win_hit ||
                   !misc_output_control_r.port_base_colour_select;
  assign col_ok  = win_hit ||
                   (misc_output_control_r.port_base_colour_select &&
                    COLOUR_DECODE_GATE_IN);
  assign stat1_port = misc_output_control_r.port_base_colour_select ?
                      `VGR_PORT_STAT1_COL : `VGR_PORT_STAT1_MONO;
  assign stat1_hit = win_hit ?
                     (port == `VGR_PORT_STAT1_MONO ||
                      port == `VGR_PORT_STAT1_COL) :
                     (port == stat1_port &&
                      (mono_ok || col_ok));

  assign CRTC_IDX_SEL_OUT =
    (io_hit || win_hit) &&
    ((port == `VGR_PORT_CRTC_IDX_MONO && mono_ok) ||
     (port == `VGR_PORT_CRTC_IDX_COL && col_ok));
  assign CRTC_DAT_SEL_OUT =
    (io_hit || win_hit) &&
    ((port == `VGR_PORT_CRTC_DAT_MONO && mono_ok) ||
     (port == `VGR_PORT_CRTC_DAT_COL && col_ok));

  // Palette ports live in the external DAC; their strobes are decoded here, and the state and write index are read back locally.
  assign pal_mask_hit = port == `VGR_PORT_PAL_MASK;
  assign pal_ridx_hit = port == `VGR_PORT_PAL_RIDX;
  assign pal_widx_hit = port == `VGR_PORT_PAL_WIDX;
  assign pal_data_hit = port == `VGR_PORT_PAL_DATA;
  assign pal_port_hit = pal_mask_hit || pal_ridx_hit ||
                        pal_widx_hit || pal_data_hit;

  // Feature control is written at the status 1 port of the current base.
  assign misc_wr_hit = wr_any && port == `VGR_PORT_MISC_WR;
  assign feat_wr_hit = wr_any && stat1_hit;

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
      misc_output_control_r <= `VGR_MISC_RESET;
    else if (misc_wr_hit)
      misc_output_control_r <= WR_DATA_IN;
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
      feature_sync_control_r <= `VGR_FEAT_RESET;
    else if (feat_wr_hit)
      feature_sync_control_r <= WR_DATA_IN;
  end

  assign HOST_VRAM_ENABLE_OUT =
    misc_output_control_r.host_vram_access_gate;
  assign DOT_CLOCK_CHOICE_OUT =
    misc_output_control_r.dot_clock_choice;

  // Even/odd addressing puts the inverted page bit in place of the address LSB.
  assign interleave_mode = SEQ_INTERLEAVE_IN && !GFX_CHAIN_ODD_EVEN_IN &&
                           !FOUR_PLANE_CHAIN_IN;
  assign VRAM_ADDR_LSB_OUT = interleave_mode ?
                             !misc_output_control_r.odd_even_bank_choice :
                             HOST_VRAM_LSB_IN;

  // Code 1 inverts horizontal sync, code 2 vertical, code 3 both.
  always_comb
  begin
    case (misc_output_control_r.retrace_pulse_sense)
      2'd0:    {vs_invert, hs_invert} = 2'b00;
      2'd1:    {vs_invert, hs_invert} = 2'b01;
      2'd2:    {vs_invert, hs_invert} = 2'b10;
      default: {vs_invert, hs_invert} = 2'b11;
    endcase
  end

  assign active_video_flag = sync_r[2] & sync_r[3];
  assign vsync_base = feature_sync_control_r[`VGR_FEAT_VBLANK_OR_BIT] ?
                      (sync_r[1] | active_video_flag) : sync_r[1];
  assign HSYNC_OUT = sync_r[0] ^ hs_invert;
  assign VSYNC_OUT = vsync_base ^ vs_invert;

  // Height report only; nothing here feeds video timing.
  always_comb
  begin
    case (misc_output_control_r.retrace_pulse_sense)
      2'b10:   SCREEN_HEIGHT_OUT = vgr_pkg::VGR_HEIGHT_350;
      2'b11:   SCREEN_HEIGHT_OUT = vgr_pkg::VGR_HEIGHT_480;
      default: SCREEN_HEIGHT_OUT = vgr_pkg::VGR_HEIGHT_400;
    endcase
  end

  always_comb
  begin
    case (PIXEL_PROBE_SELECT_IN)
      2'd0:    pixel_pair = {sync_r[6], sync_r[4]};
      2'd1:    pixel_pair = {sync_r[9], sync_r[8]};
      2'd2:    pixel_pair = {sync_r[7], sync_r[6]};
      default: pixel_pair = {sync_r[11], sync_r[10]};
    endcase
  end

  // No switches are fitted, so the sense bit is tied low.
  assign stat0_word = {VERT_IRQ_PENDING_IN, 2'b00, 1'b0,
                       4'h0};
  // Bit 0 reads 1 during blanking, the inverse of active video.
  assign stat1_word = {2'b00, pixel_pair, sync_r[1], 2'b00,
                       ~active_video_flag};

  always_comb
  begin
    rd_data_nxt = 8'h00;
    if (port == `VGR_PORT_MISC_RD)
      rd_data_nxt = misc_output_control_r;
    else if (port == `VGR_PORT_FEAT_RD)
      rd_data_nxt = feature_sync_control_r;
    else if (port == `VGR_PORT_MISC_WR)
      rd_data_nxt = stat0_word;
    else if (stat1_hit)
      rd_data_nxt = stat1_word;
    else if (port == `VGR_PORT_PAL_RIDX)
      rd_data_nxt = previous_palette_direction_r ?
                    `VGR_STATE_READ : `VGR_STATE_WRITE;
    else if (port == `VGR_PORT_PAL_WIDX)
      rd_data_nxt = palette_write_pointer_r;
    else if (port == `VGR_PORT_PAL_DATA || port == `VGR_PORT_PAL_MASK)
      rd_data_nxt = DAC_RD_DATA_IN;
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
      rd_valid_r <= 1'b0;
    else
      rd_valid_r <= rd_any;
  end

  // Read data holds until the next read, so a slow host can still take it.
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
      rd_data_r <= 8'h00;
    else if (rd_any)
      rd_data_r <= rd_data_nxt;
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
      attr_clear_r <= 1'b0;
    else
      attr_clear_r <= rd_any && stat1_hit;
  end

  // Palette pointers and triplet phases.
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      palette_read_pointer_r <= `VGR_INDEX_RESET;
      read_phase_r           <= 2'b00;
    end
    else if (wr_any && port == `VGR_PORT_PAL_RIDX)
    begin
      palette_read_pointer_r <= WR_DATA_IN;
      read_phase_r           <= 2'b00;
    end
    else if (rd_any && port == `VGR_PORT_PAL_DATA)
    begin
      if (read_phase_r == `VGR_PHASE_LAST)
      begin
        read_phase_r           <= 2'b00;
        palette_read_pointer_r <= palette_read_pointer_r + 8'h01;
      end
      else
        read_phase_r <= read_phase_r + 2'b01;
    end
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      palette_write_pointer_r <= `VGR_INDEX_RESET;
      write_phase_r           <= 2'b00;
    end
    else if (wr_any && port == `VGR_PORT_PAL_WIDX)
    begin
      palette_write_pointer_r <= WR_DATA_IN;
      write_phase_r           <= 2'b00;
    end
    else if (wr_any && port == `VGR_PORT_PAL_DATA)
    begin
      if (write_phase_r == `VGR_PHASE_LAST)
      begin
        write_phase_r           <= 2'b00;
        palette_write_pointer_r <= palette_write_pointer_r + 8'h01;
      end
      else
        write_phase_r <= write_phase_r + 2'b01;
    end
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
      previous_palette_direction_r <= 1'b0;
    else if (rd_any && port == `VGR_PORT_PAL_DATA)
      previous_palette_direction_r <= 1'b1;
    else if (wr_any && port == `VGR_PORT_PAL_DATA)
      previous_palette_direction_r <= 1'b0;
  end

  // Palette writes and data-port reads become one-cycle strobes on the DAC port.
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
      dac_req_r <= '0;
    else
    begin
      // Index, mask and data writes all go out; both index pointers are also tracked here.
      dac_req_r.wr   <= wr_any && pal_port_hit;
      dac_req_r.rd   <= rd_any && pal_data_hit;
      dac_req_r.addr <= port[1:0] + 2'b10;
      dac_req_r.data <= WR_DATA_IN;
    end
  end

  assign RD_DATA_OUT           = rd_data_r;
  assign RD_VALID_OUT          = rd_valid_r;
  assign ATTR_TOGGLE_CLEAR_OUT = attr_clear_r;
  assign DAC_WR_OUT            = dac_req_r.wr;
  assign DAC_RD_OUT            = dac_req_r.rd;
  assign DAC_ADDR_OUT          = dac_req_r.addr;
  assign DAC_WR_DATA_OUT       = dac_req_r.data;

endmodule

// ---- sim/vgr_dac_model.sv ----
// Behavioural palette DAC with its own lookup table and index counters.
`timescale 1ns/100ps
module vgr_dac_model
(
  input  wire logic       clk_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  input  wire logic [1:0] addr_in,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out
);
  logic [7:0] lut [256][3];
  logic [7:0] ridx_r = 8'h00;
  logic [7:0] widx_r = 8'h00;
  logic [1:0] rph_r  = 2'h0;
  logic [1:0] wph_r  = 2'h0;

  // Moves to the next colour of a triplet, then to the next entry.
  function automatic logic [9:0] step(input logic [7:0] i,
                                      input logic [1:0] p);
    step = (p == 2'h2) ? {i + 8'h01, 2'h0} : {i, p + 2'h1};
  endfunction

  assign data_out = lut[ridx_r][rph_r];

  always @(posedge clk_in)
  begin
    if (wr_in && addr_in == 2'h1)
      {ridx_r, rph_r} <= {data_in, 2'h0};
    if (wr_in && addr_in == 2'h2)
      {widx_r, wph_r} <= {data_in, 2'h0};
    if (wr_in && addr_in == 2'h3)
    begin
      lut[widx_r][wph_r] <= data_in;
      {widx_r, wph_r} <= step(widx_r, wph_r);
    end
    if (rd_in && addr_in == 2'h3)
      {ridx_r, rph_r} <= step(ridx_r, rph_r);
  end
endmodule

// ---- sim/vgr_general_regs_chk.sv ----
// Port-level assertions for the general VGA register group.
`timescale 1ns/100ps
module vgr_general_regs_chk
(
  input wire logic        CLK_SYS_IN,
  input wire logic        RST_N_IN,
  input wire logic        IO_WR_IN,
  input wire logic        IO_RD_IN,
  input wire logic [15:0] IO_ADDR_IN,
  input wire logic [7:0]  WR_DATA_IN,
  input wire logic        COLOUR_DECODE_GATE_IN,
  input wire logic        SEQ_INTERLEAVE_IN,
  input wire logic        GFX_CHAIN_ODD_EVEN_IN,
  input wire logic        FOUR_PLANE_CHAIN_IN,
  input wire logic        HOST_VRAM_LSB_IN,
  input wire logic [7:0]  RD_DATA_OUT,
  input wire logic        RD_VALID_OUT,
  input wire logic        CRTC_IDX_SEL_OUT,
  input wire logic        CRTC_DAT_SEL_OUT,
  input wire logic        HOST_VRAM_ENABLE_OUT,
  input wire logic        VRAM_ADDR_LSB_OUT,
  input wire logic [1:0]  DOT_CLOCK_CHOICE_OUT,
  input wire logic [1:0]  SCREEN_HEIGHT_OUT,
  input wire logic        ATTR_TOGGLE_CLEAR_OUT,
  input wire logic        DAC_WR_OUT,
  input wire logic [1:0]  DAC_ADDR_OUT,
  input wire logic [7:0]  DAC_WR_DATA_OUT
);
  // Copy of the misc register, written only through its fixed I/O port.
  logic [7:0]  misc_r;
  logic        misc_wr;
  logic [15:0] base_a;
  logic        io_ok;
  assign misc_wr = IO_WR_IN && IO_ADDR_IN == 16'h03c2;
  // Colour ports answer on I/O only while the decode gate is open.
  assign io_ok   = !misc_r[0] || COLOUR_DECODE_GATE_IN;
  assign base_a  = misc_r[0] ? 16'h03d0 : 16'h03b0;
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
      misc_r <= 8'h00;
    else if (misc_wr)
      misc_r <= WR_DATA_IN;
  end

  function automatic logic [1:0] height(input logic [1:0] c);
    height = (c == 2'h2) ? 2'h1 : (c == 2'h3) ? 2'h2 : 2'h0;
  endfunction

  a_crtc_base_on: assert property (
    IO_WR_IN && io_ok && IO_ADDR_IN == (base_a | 16'h0004)
      |-> CRTC_IDX_SEL_OUT)
    else $error("crtc index not decoded at current base");
  a_crtc_data_sel: assert property (
    IO_WR_IN && io_ok && IO_ADDR_IN == (base_a | 16'h0005)
      |-> CRTC_DAT_SEL_OUT)
    else $error("crtc data not decoded at current base");
  a_crtc_base_off: assert property (
    IO_ADDR_IN == (base_a ^ 16'h0064) |-> !CRTC_IDX_SEL_OUT)
    else $error("crtc index decoded at other base");
  a_vram_gate: assert property (misc_wr |=>
    HOST_VRAM_ENABLE_OUT == $past(WR_DATA_IN[1]))
    else $error("host memory gate does not follow misc");
  a_dot_clock: assert property (misc_wr |=>
    DOT_CLOCK_CHOICE_OUT == $past(WR_DATA_IN[3:2]))
    else $error("dot clock choice does not follow misc");
  a_height_code: assert property (misc_wr |=>
    SCREEN_HEIGHT_OUT == height($past(WR_DATA_IN[7:6])))
    else $error("screen height code wrong");
  a_page_lsb: assert property (
    VRAM_ADDR_LSB_OUT == ((SEQ_INTERLEAVE_IN && !GFX_CHAIN_ODD_EVEN_IN
      && !FOUR_PLANE_CHAIN_IN) ? !misc_r[5] : HOST_VRAM_LSB_IN))
    else $error("memory address lsb wrong");
  a_stat0_switch: assert property (
    IO_RD_IN && IO_ADDR_IN == 16'h03c2 |=> RD_VALID_OUT && !RD_DATA_OUT[4])
    else $error("switch sense not zero");
  a_attr_clear: assert property (
    IO_RD_IN && io_ok && IO_ADDR_IN == (base_a | 16'h000a)
      |=> ATTR_TOGGLE_CLEAR_OUT)
    else $error("attribute toggle not cleared");
  a_state_equal: assert property (
    IO_RD_IN && IO_ADDR_IN == 16'h03c7 |=> RD_DATA_OUT[0] == RD_DATA_OUT[1])
    else $error("palette state bits differ");
  a_dac_forward: assert property (
    IO_WR_IN && IO_ADDR_IN inside {[16'h03c6:16'h03c9]} |=> DAC_WR_OUT
      && DAC_ADDR_OUT == $past(IO_ADDR_IN[1:0]) + 2'h2
      && DAC_WR_DATA_OUT == $past(WR_DATA_IN))
    else $error("palette write not forwarded");

  c_colour_mode: cover property (misc_wr && WR_DATA_IN[0]);
  c_data_read: cover property (IO_RD_IN && IO_ADDR_IN == 16'h03c9);
  c_attr_pulse: cover property (ATTR_TOGGLE_CLEAR_OUT);
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the general VGA register group.
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  err_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module testbench;
  logic CLK_SYS_IN = 0, RST_N_IN = 0, IO_WR_IN = 0, IO_RD_IN = 0;
  logic MEM_WR_IN = 0, MEM_RD_IN = 0, LEGACY_UNIT_ON_IN = 0;
  logic COLOUR_DECODE_GATE_IN = 1, VIDEO_HSYNC_IN = 0, VIDEO_VSYNC_IN = 0;
  logic HORIZ_ACTIVE_IN = 0, VERT_ACTIVE_IN = 0, VERT_IRQ_PENDING_IN = 0;
  logic SEQ_INTERLEAVE_IN = 0, GFX_CHAIN_ODD_EVEN_IN = 0;
  logic FOUR_PLANE_CHAIN_IN = 0, HOST_VRAM_LSB_IN = 0;
  logic [15:0] IO_ADDR_IN = 0;
  logic [19:0] MEM_ADDR_IN = 0;
  logic [7:0]  WR_DATA_IN = 0, PIXEL_FIFO_IN = 0, DAC_RD_DATA_IN;
  logic [1:0]  PIXEL_PROBE_SELECT_IN = 0;
  logic [7:0]  RD_DATA_OUT, DAC_WR_DATA_OUT;
  logic        RD_VALID_OUT, CRTC_IDX_SEL_OUT, CRTC_DAT_SEL_OUT, HSYNC_OUT;
  logic        HOST_VRAM_ENABLE_OUT, VRAM_ADDR_LSB_OUT, VSYNC_OUT;
  logic        ATTR_TOGGLE_CLEAR_OUT, DAC_WR_OUT, DAC_RD_OUT;
  logic [1:0]  DOT_CLOCK_CHOICE_OUT, SCREEN_HEIGHT_OUT, DAC_ADDR_OUT;
  int          err_count = 0, num_checks = 0, cyc = 0;

  vgr_general_regs u_vgr_general_regs
  (
    .CLK_SYS_IN, .RST_N_IN, .IO_WR_IN, .IO_RD_IN, .IO_ADDR_IN, .MEM_WR_IN,
    .MEM_RD_IN, .MEM_ADDR_IN, .WR_DATA_IN, .LEGACY_UNIT_ON_IN,
    .COLOUR_DECODE_GATE_IN, .VIDEO_HSYNC_IN, .VIDEO_VSYNC_IN,
    .HORIZ_ACTIVE_IN, .VERT_ACTIVE_IN, .PIXEL_FIFO_IN, .PIXEL_PROBE_SELECT_IN,
    .VERT_IRQ_PENDING_IN, .SEQ_INTERLEAVE_IN, .GFX_CHAIN_ODD_EVEN_IN,
    .FOUR_PLANE_CHAIN_IN, .HOST_VRAM_LSB_IN, .DAC_RD_DATA_IN, .RD_DATA_OUT,
    .RD_VALID_OUT, .CRTC_IDX_SEL_OUT, .CRTC_DAT_SEL_OUT, .HOST_VRAM_ENABLE_OUT,
    .VRAM_ADDR_LSB_OUT, .DOT_CLOCK_CHOICE_OUT, .HSYNC_OUT, .VSYNC_OUT,
    .SCREEN_HEIGHT_OUT, .ATTR_TOGGLE_CLEAR_OUT, .DAC_WR_OUT, .DAC_RD_OUT,
    .DAC_ADDR_OUT, .DAC_WR_DATA_OUT
  );
  vgr_dac_model u_vgr_dac_model
  (
    .clk_in(CLK_SYS_IN), .wr_in(DAC_WR_OUT), .rd_in(DAC_RD_OUT),
    .addr_in(DAC_ADDR_OUT), .data_in(DAC_WR_DATA_OUT),
    .data_out(DAC_RD_DATA_IN)
  );

  initial
  begin
    forever #4 CLK_SYS_IN = ~CLK_SYS_IN;
  end

  // One host access: m picks the memory window, wr the direction.
  task acc(input bit m, input bit wr, input logic [19:0] a,
           input logic [7:0] d);
    @(posedge CLK_SYS_IN);
    {IO_WR_IN, IO_RD_IN} <= m ? 2'h0 : {wr, ~wr};
    {MEM_WR_IN, MEM_RD_IN} <= m ? {wr, ~wr} : 2'h0;
    IO_ADDR_IN <= a[15:0];
    MEM_ADDR_IN <= a;
    WR_DATA_IN <= d;
    @(posedge CLK_SYS_IN);
    {IO_WR_IN, IO_RD_IN, MEM_WR_IN, MEM_RD_IN} <= 4'h0;
    #1;
  endtask

  task t_misc();
    logic [7:0] d;
    {SEQ_INTERLEAVE_IN, VIDEO_HSYNC_IN, VIDEO_VSYNC_IN} <= 3'h7;
    for (int c = 0; c < 4; c++)
    begin
      d = {c[1:0], c[0], 1'b0, c[1:0], ~c[0], 1'b0};
      acc(0, 1, 20'h0_03c2, d);
      repeat (4) @(posedge CLK_SYS_IN);
      #1;
      `CHK("hsync", ~c[0], HSYNC_OUT)
      `CHK("vsync", ~c[1], VSYNC_OUT)
      `CHK("dot clock", c[1:0], DOT_CLOCK_CHOICE_OUT)
      `CHK("vram gate", ~c[0], HOST_VRAM_ENABLE_OUT)
      `CHK("height", (c > 1) ? c[1:0] - 2'h1 : 2'h0, SCREEN_HEIGHT_OUT)
      `CHK("page lsb", ~c[0], VRAM_ADDR_LSB_OUT)
      acc(0, 0, 20'h0_03cc, 8'h00);
      `CHK("misc read", d, RD_DATA_OUT)
    end
  endtask

  task t_stat();
    {HORIZ_ACTIVE_IN, VERT_ACTIVE_IN, PIXEL_PROBE_SELECT_IN} <= 4'hf;
    PIXEL_FIFO_IN <= 8'h80;
    for (int m = 0; m < 2; m++)
    begin
      acc(0, 1, 20'h0_03c2, {7'h01, m[0]});
      acc(0, 1, 20'h0_03b4, 8'h11);
      acc(0, 1, 20'h0_03d4, 8'h22);
      acc(0, 1, 20'h0_03b5, 8'h33);
      acc(0, 1, 20'h0_03d5, 8'h44);
      acc(0, 0, m ? 20'h0_03da : 20'h0_03ba, 8'h00);
      `CHK("status one", 8'h28, RD_DATA_OUT & 8'h39)
      VERT_IRQ_PENDING_IN <= m[0];
      acc(0, 0, 20'h0_03c2, 8'h00);
      `CHK("status zero", {m[0], 7'h00}, RD_DATA_OUT & 8'h90)
    end
    VIDEO_VSYNC_IN <= 1'b0;
    for (int f = 0; f < 2; f++)
    begin
      acc(0, 1, 20'h0_03da, {4'h0, f[0], 3'h0});
      repeat (4) @(posedge CLK_SYS_IN);
      #1;
      `CHK("vsync blank", f[0], VSYNC_OUT)
    end
    acc(0, 0, 20'h0_0300, 8'h00);
    `CHK("unmapped", 8'h00, RD_DATA_OUT)
  endtask

  task t_palette();
    acc(0, 1, 20'h0_03c8, 8'hff);
    for (int i = 0; i < 6; i++)
      acc(0, 1, 20'h0_03c9, 8'h40 + i[7:0]);
    acc(0, 0, 20'h0_03c7, 8'h00);
    `CHK("state", 8'h00, RD_DATA_OUT & 8'h03)
    acc(0, 0, 20'h0_03c8, 8'h00);
    `CHK("write index", 8'h01, RD_DATA_OUT)
    acc(0, 1, 20'h0_03c7, 8'hff);
    for (int i = 0; i < 6; i++)
    begin
      acc(0, 0, 20'h0_03c9, 8'h00);
      `CHK("colour", 8'h40 + i[7:0], RD_DATA_OUT)
    end
    acc(0, 0, 20'h0_03c7, 8'h00);
    `CHK("state", 8'h03, RD_DATA_OUT & 8'h03)
  endtask

  task t_window();
    COLOUR_DECODE_GATE_IN <= 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      LEGACY_UNIT_ON_IN <= (k != 1);
      acc(1, 1, (k == 2) ? 20'h0_53c8 : 20'h0_43c8, 8'h5a);
      `CHK("window", k == 0, DAC_WR_OUT)
    end
    acc(1, 0, 20'h0_43da, 8'h00);
    `CHK("window status", 8'h20, RD_DATA_OUT & 8'h39)
  endtask

  task results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge CLK_SYS_IN)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      results();
    end
  end

  initial
  begin
    repeat (20) @(posedge CLK_SYS_IN);
    RST_N_IN <= 1'b1;
    t_misc();
    t_stat();
    t_palette();
    t_window();
    results();
  end
endmodule

bind vgr_general_regs vgr_general_regs_chk u_vgr_general_regs_chk
(
  .CLK_SYS_IN, .RST_N_IN, .IO_WR_IN, .IO_RD_IN, .IO_ADDR_IN, .WR_DATA_IN,
  .COLOUR_DECODE_GATE_IN, .CRTC_DAT_SEL_OUT,
  .SEQ_INTERLEAVE_IN, .GFX_CHAIN_ODD_EVEN_IN, .FOUR_PLANE_CHAIN_IN,
  .HOST_VRAM_LSB_IN, .RD_DATA_OUT, .RD_VALID_OUT, .CRTC_IDX_SEL_OUT,
  .HOST_VRAM_ENABLE_OUT, .VRAM_ADDR_LSB_OUT, .DOT_CLOCK_CHOICE_OUT,
  .SCREEN_HEIGHT_OUT, .ATTR_TOGGLE_CLEAR_OUT, .DAC_WR_OUT, .DAC_ADDR_OUT,
  .DAC_WR_DATA_OUT
);
